// file: tic_capmem.sv
// capture value store, one word per channel, registered read
// assumes several channels may capture in the same cycle
`timescale 1ns/10ps
module tic_capmem #(
	parameter int N = 8,  // words
	parameter int W = 16  // word width
) (
	input  wire logic         core_clk, // block clock
	input  wire logic         rst_n,    // sync reset, active low
	input  wire logic [N-1:0] we,       // per word write strobe
	input  wire logic [W-1:0] wdata,    // value to store
	input  wire logic [2:0]   raddr,    // read word
	output logic      [W-1:0] rdata     // registered read data
);
	logic [W-1:0] mem [N]; // stored values

	// each word keeps its value until its own strobe
	for (genvar i = 0; i < N; i++)
	begin : g_w
		always_ff @(posedge core_clk)
		begin
			if (!rst_n)
				mem[i] <= '0;
			else if (we[i])
				mem[i] <= wdata;
		end
	end

	// read port, readable any time
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end
endmodule

// file: tic_capture_unit.sv
// eight channel input capture unit with its base timer and apb slave
// assumes apb master on core_clk; trigger pins are asynchronous
`timescale 1ns/10ps
module tic_capture_unit #(
	parameter int PS_W = 8 // prescale register width
) (
	input  wire logic        core_clk,          // 20 mhz clock
	input  wire logic        rst_n,             // sync reset
	input  wire logic [11:0] paddr,             // apb address
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb enable
	input  wire logic        pwrite,            // apb direction
	input  wire logic [31:0] pwdata,            // apb write data
	output logic      [31:0] prdata,            // apb read data
	output logic             pready,            // apb ready
	output logic             pslverr,           // apb error
	input  wire logic [7:0]  trigger_input_pin, // trigger pins
	output logic             irq                // level interrupt
);
	localparam int CW = tic_pkg::CNT_W;

	logic [CW-1:0]    count;        // base timer
	logic             bt_run;       // base timer runs
	logic             reset_on_ch0_match_bit; // ch0 match reset
	logic [7:0]       bt_div;       // base clock divider
	logic [7:0]       div_cnt;      // divider counter
	logic             bt_tick;      // base timer clock strobe
	logic             half;         // halved clock strobe
	logic [CW-1:0]    channel0_compare_register; // ch0 compare
	logic [CW-1:0]    gcmp [6:7];   // gate compare 4 and 5
	logic [7:0]       function_select_register;  // 1 = capture
	logic [7:0]       channel_enable_register;   // 1 = running
	logic [7:0]       channel_request_flags;     // sticky flags
	logic [7:0]       mask;         // interrupt mask
	tic_pkg::tic_cctl_t cctl [8];   // capture control registers
	logic [PS_W-1:0]  psc [6:7];    // trigger prescale registers
	logic [PS_W-1:0]  ps_cnt [6:7]; // prescale counters
	logic [7:6]       closed;       // gate closed
	logic [7:0]       active;       // channel measuring
	logic [7:0]       lvl;          // filtered pin levels
	logic [7:0]       prev;         // previous filtered level
	logic [7:0]       trig;         // accepted trigger
	logic [7:0]       cap;          // capture instant
	logic [CW-1:0]    mem_rdata;    // capture store read data
	logic [31:0]      next_prdata;  // read mux
	logic             acc;          // apb access phase
	logic             wr;           // write completes
	logic             rd;           // read completes

	// true for every mapped register address
	function automatic logic mapped(input logic [11:0] a);
		mapped = (a[11:7] == 5'h00) && (a[1:0] == 2'h0) &&
			(a <= tic_pkg::A_COUNT || a >= tic_pkg::A_CAPV);
	endfunction

	// true when a sits in the 8 word window at base
	function automatic logic in_win(input logic [11:0] a,
		input logic [11:0] base);
		in_win = (a[11:5] == base[11:5]) && (a[1:0] == 2'h0);
	endfunction

	assign acc = psel & penable;
	assign wr  = acc & pready & pwrite;
	assign rd  = acc & pready & ~pwrite;

	// one wait state: ready in the second access cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~mapped(paddr);
		end
	end

	// base control and compare registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			bt_run                    <= 1'b0;
			reset_on_ch0_match_bit    <= 1'b0;
			bt_div                    <= 8'h00;
			channel0_compare_register <= '0;
			gcmp[6]                   <= '0;
			gcmp[7]                   <= '0;
		end
		else if (wr)
		begin
			case (paddr)
				tic_pkg::A_BCTL:
				begin
					bt_run <= pwdata[tic_pkg::BC_RUN];
					reset_on_ch0_match_bit <= pwdata[tic_pkg::BC_RST];
					bt_div <= pwdata[tic_pkg::BC_DIV +: 8];
				end
				tic_pkg::A_CMP0:  channel0_compare_register <= pwdata[CW-1:0];
				tic_pkg::A_GCMP4: gcmp[6] <= pwdata[CW-1:0];
				tic_pkg::A_GCMP5: gcmp[7] <= pwdata[CW-1:0];
				default:          ;
			endcase
		end
	end

	// channel setup registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			function_select_register <= 8'h00;
			channel_enable_register  <= 8'h00;
			mask                     <= 8'h00;
			psc[6]                   <= '0;
			psc[7]                   <= '0;
			for (int i = 0; i < 8; i++)
				cctl[i] <= tic_pkg::CCTL_RST;
		end
		else if (wr)
		begin
			// software selects capture and enables channel
			if (paddr == tic_pkg::A_FSEL)
				function_select_register <= pwdata[7:0];
			if (paddr == tic_pkg::A_CHEN)
				channel_enable_register <= pwdata[7:0];
			if (paddr == tic_pkg::A_MASK)
				mask <= pwdata[7:0];
			if (paddr == tic_pkg::A_PSC6)
				psc[6] <= pwdata[PS_W-1:0];
			if (paddr == tic_pkg::A_PSC7)
				psc[7] <= pwdata[PS_W-1:0];
			if (in_win(paddr, tic_pkg::A_CCTL))
				cctl[paddr[4:2]] <= pwdata[8:0];
		end
	end

	// base timer clock strobe from divider, halved strobe
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			div_cnt <= 8'h00;
			half    <= 1'b0;
		end
		else
		begin
			half    <= ~half;
			div_cnt <= (div_cnt >= bt_div) ? 8'h00 : div_cnt + 8'h01;
		end
	end
	assign bt_tick = bt_run & (div_cnt >= bt_div);

	// base timer, optionally reset after ch0 compare plus one
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			count <= '0;
		else if (bt_tick)
		begin
			if (reset_on_ch0_match_bit &&
				count == channel0_compare_register + CW'(1))
				count <= '0;
			else
				count <= count + CW'(1);
		end
	end

	assign active = channel_enable_register & function_select_register;

	// per channel filter, edge detect and capture decision
	for (genvar j = 0; j < 8; j++)
	begin : g_ch
		logic       se;    // filter sample strobe
		logic       deb;   // debounce in use
		logic       edg;   // selected edge seen
		logic [1:0] fs;    // filter clock select

		assign fs  = cctl[j].filt_sel;
		assign deb = (j == 7) && cctl[j].debounce;
		// filter sample clock select
		always_comb
		begin
			case (fs)
				tic_pkg::FCK_F1: se = 1'b1;
				tic_pkg::FCK_F2: se = half;
				tic_pkg::FCK_BT: se = bt_tick;
				default:         se = deb;
			endcase
		end

		tic_filter u_filt (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.pin       (trigger_input_pin[j]),
			.filt_on   ((fs != 2'h0) | deb),
			.sample_en (se),
			.need      (deb ? tic_pkg::DEB_N : tic_pkg::FILT_N),
			.level     (lvl[j])
		);

		// edge select decode
		always_comb
		begin
			case (cctl[j].edge_sel)
				tic_pkg::EDGE_RISE: edg = lvl[j] & ~prev[j];
				tic_pkg::EDGE_FALL: edg = ~lvl[j] & prev[j];
				tic_pkg::EDGE_BOTH: edg = lvl[j] ^ prev[j];
				default:            edg = 1'b0;
			endcase
		end

		// only a running channel accepts triggers
		assign trig[j] = edg & active[j];

		if (j >= 6)
		begin : g_gp
			logic pre_ok; // prescale count reached

			assign pre_ok = ~cctl[j].prescale_en ||
				ps_cnt[j] == psc[j];
			// closed gate ignores triggers
			assign cap[j] = trig[j] & ~closed[j] & pre_ok;

			// prescale counter of accepted triggers
			always_ff @(posedge core_clk)
			begin
				if (!rst_n || !active[j] || !cctl[j].prescale_en)
					ps_cnt[j] <= '0;
				else if (trig[j] && !closed[j])
					ps_cnt[j] <= pre_ok ? '0 : ps_cnt[j] + PS_W'(1);
			end

			// gate closes after capture, may reopen on match
			always_ff @(posedge core_clk)
			begin
				if (!rst_n || !active[j] || !cctl[j].gate_en)
					closed[j] <= 1'b0;
				else if (cctl[j].gate_goc && closed[j] &&
					count == gcmp[j])
					closed[j] <= 1'b0;
				else if (cap[j])
					closed[j] <= 1'b1;
			end
		end
		else
		begin : g_plain
			assign cap[j] = trig[j];
		end
	end

	// filtered level history for edge detection
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			prev <= 8'h00;
		else
			prev <= lvl;
	end

	// capture store; each capture overwrites its word
	tic_capmem #(
		.N (8),
		.W (CW)
	) u_mem (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.we       (cap),
		.wdata    (count),
		.raddr    (paddr[4:2]),
		.rdata    (mem_rdata)
	);

	// request flags: capture sets, a read clears only the bits it
	// returned, so a capture landing between sample and clear survives
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			channel_request_flags <= 8'h00;
		else if (rd && paddr == tic_pkg::A_FLAGS)
			channel_request_flags <= (channel_request_flags &
				~prdata[7:0]) | cap;
		else
			channel_request_flags <= channel_request_flags | cap;
	end

	assign irq = |(channel_request_flags & mask);

	// read mux; unmapped reads return zero
	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (in_win(paddr, tic_pkg::A_CCTL))
			next_prdata = {23'h000000, cctl[paddr[4:2]]};
		else if (in_win(paddr, tic_pkg::A_CAPV))
			next_prdata = {16'h0000, mem_rdata};
		else
		begin
			case (paddr)
				tic_pkg::A_BCTL: next_prdata = {16'h0000, bt_div,
					6'h00, reset_on_ch0_match_bit, bt_run};
				tic_pkg::A_CMP0:  next_prdata[CW-1:0] = channel0_compare_register;
				tic_pkg::A_GCMP4: next_prdata[CW-1:0] = gcmp[6];
				tic_pkg::A_GCMP5: next_prdata[CW-1:0] = gcmp[7];
				tic_pkg::A_FSEL:  next_prdata[7:0] = function_select_register;
				tic_pkg::A_CHEN:  next_prdata[7:0] = channel_enable_register;
				tic_pkg::A_FLAGS: next_prdata[7:0] = channel_request_flags;
				tic_pkg::A_MASK:  next_prdata[7:0] = mask;
				tic_pkg::A_PSC6:  next_prdata[PS_W-1:0] = psc[6];
				tic_pkg::A_PSC7:  next_prdata[PS_W-1:0] = psc[7];
				tic_pkg::A_COUNT: next_prdata[CW-1:0] = count;
				default:          ;
			endcase
		end
	end

	// read data captured in the first access cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			prdata <= 32'h0000_0000;
		else if (acc && !pready)
			prdata <= next_prdata;
	end

	// captures set the flag on the next edge
	a_flag_on_cap: assert property (@(posedge core_clk) disable iff (!rst_n)
		cap[0] |=> channel_request_flags[0])
		else $error("capture did not raise request flag");

	// disabled channels never capture
	a_no_cap_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		!active[3] |-> !cap[3])
		else $error("capture on disabled channel");

	// closed gate blocks captures
	a_gate_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
		closed[7] |-> !cap[7])
		else $error("capture through closed gate");

	// gate reopens on gate compare match
	a_gate_reopen: assert property (@(posedge core_clk) disable iff (!rst_n)
		active[7] && cctl[7].gate_en && cctl[7].gate_goc && closed[7] &&
		count == gcmp[7] |=> !closed[7])
		else $error("gate failed to reopen on match");

	// period of ch0 match reset is compare plus two
	a_timer_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
		bt_tick && reset_on_ch0_match_bit &&
		count == channel0_compare_register + CW'(1) |=> count == '0)
		else $error("base timer did not wrap at compare plus one");

	// prescaled capture only when counter equals prescale value
	a_psc_period: assert property (@(posedge core_clk) disable iff (!rst_n)
		cap[6] && cctl[6].prescale_en |-> ps_cnt[6] == psc[6] ##1
		ps_cnt[6] == '0)
		else $error("prescaled capture at wrong count");

	// rising edge selection only fires on a high level
	a_edge_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig[1] && cctl[1].edge_sel == tic_pkg::EDGE_RISE |->
		lvl[1] && !prev[1])
		else $error("rising trigger without rising level");

	// without prescaler or closed gate every trigger captures
	a_every_trig: assert property (@(posedge core_clk) disable iff (!rst_n)
		trig[6] && !cctl[6].prescale_en && !closed[6] |-> cap[6])
		else $error("trigger without capture");
endmodule

// file: tic_filter.sv
// sampled digital filter for one trigger input pin
// assumes pin is asynchronous; sample_en comes from core_clk logic
`timescale 1ns/10ps
module tic_filter (
	input  wire logic       core_clk,  // block clock
	input  wire logic       rst_n,     // sync reset, active low
	input  wire logic       pin,       // raw trigger pin
	input  wire logic       filt_on,   // filter in use
	input  wire logic       sample_en, // sample strobe
	input  wire logic [3:0] need,      // matching samples needed
	output logic            level      // filtered level
);
	logic       s1;   // first synchroniser stage
	logic       s2;   // second synchroniser stage
	logic       last; // previous sample
	logic [3:0] run;  // matching sample count

	// two-stage synchroniser
	always_ff @(posedge core_clk)
	begin
		s1 <= rst_n ? pin : 1'b0;
		s2 <= rst_n ? s1 : 1'b0;
	end

	// count equal samples and pass the level once enough match
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			last  <= 1'b0;
			run   <= 4'h0;
			level <= 1'b0;
		end
		else if (!filt_on)
		begin
			// bypass: synchronised level passes straight
			last  <= s2;
			run   <= 4'h0;
			level <= s2;
		end
		else if (sample_en)
		begin
			last <= s2;
			if (s2 != last)
				run <= 4'h1;
			else if (run < need)
				run <= run + 4'h1;
			if (s2 == last && run + 4'h1 >= need)
				level <= s2;
		end
	end
endmodule

// file: tic_pkg.sv
// constants and types for the input capture unit
// assumes an apb master on core_clk and a free-running base timer
// Overview of operation
// - trigger event copies base count to capture
// - trigger edge: rising, falling or both
// - cleared enable stops captures and requests
// - no prescaler: capture on every trigger
// - channels 6,7 prescale: capture every N+1
// - capture sets that channel's request flag
// - filter passes level after three samples
// - gate ignores triggers after first capture
// - gate reopens on compare 4 or 5 match
// - channel 7 offers digital debounce option
// - edge field encoding 01 means rising
// - ch0 match reset gives period n plus 2
package tic_pkg;
	localparam int CNT_W = 16;               // base timer width
	localparam int NCH   = 8;                // channel count
	// register byte offsets
	localparam logic [11:0] A_BCTL  = 12'h000; // run, ch0 reset, divider
	localparam logic [11:0] A_CMP0  = 12'h004; // channel 0 compare
	localparam logic [11:0] A_GCMP4 = 12'h008; // gate compare 4
	localparam logic [11:0] A_GCMP5 = 12'h00c; // gate compare 5
	localparam logic [11:0] A_FSEL  = 12'h010; // function select
	localparam logic [11:0] A_CHEN  = 12'h014; // channel enable
	localparam logic [11:0] A_FLAGS = 12'h018; // request flags, read clears
	localparam logic [11:0] A_MASK  = 12'h01c; // interrupt mask
	localparam logic [11:0] A_CCTL  = 12'h020; // 8 control words
	localparam logic [11:0] A_PSC6  = 12'h040; // prescale channel 6
	localparam logic [11:0] A_PSC7  = 12'h044; // prescale channel 7
	localparam logic [11:0] A_COUNT = 12'h048; // live base count
	localparam logic [11:0] A_CAPV  = 12'h060; // 8 capture values
	// base control field positions
	localparam int BC_RUN = 0;               // base timer runs
	localparam int BC_RST = 1;               // reset on ch0 match
	localparam int BC_DIV = 8;               // low bit of divider
	// edge select encodings
	localparam logic [1:0] EDGE_RISE = 2'h1; // rising edge
	localparam logic [1:0] EDGE_FALL = 2'h2; // falling edge
	localparam logic [1:0] EDGE_BOTH = 2'h3; // both edges
	// filter clock select encodings
	localparam logic [1:0] FCK_F1 = 2'h1;    // every core clock
	localparam logic [1:0] FCK_F2 = 2'h2;    // every second clock
	localparam logic [1:0] FCK_BT = 2'h3;    // base timer clock
	localparam logic [3:0] FILT_N = 4'h3;    // samples to pass
	localparam logic [3:0] DEB_N  = 4'h8;    // debounce samples
	localparam logic [8:0] CCTL_RST = 9'h000; // control reset value
	// per channel capture control word
	typedef struct packed {
		logic       debounce;    // bit 8, channel 7 only
		logic       prescale_en; // bit 7
		logic       gate_aux;    // bit 6, stored only
		logic       gate_goc;    // bit 5
		logic       gate_en;     // bit 4
		logic [1:0] filt_sel;    // bits 3:2
		logic [1:0] edge_sel;    // bits 1:0
	} tic_cctl_t;
endpackage

// file: tic_trig_src.sv
// trigger source model that stands in front of the capture pins
// assumes toggle requests come from the bench, changed after core_clk
`timescale 1ns/10ps
module tic_trig_src (
	input  wire logic       core_clk, // block clock
	input  wire logic       rst_n,    // sync reset, active low
	input  wire logic       go,       // toggle request
	input  wire logic [2:0] ch,       // pin to toggle
	output logic      [7:0] pins      // driven trigger levels
);
	// one edge per request; pins are plain levels, never released
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			pins <= 8'h00;
		else if (go)
			pins[ch] <= ~pins[ch];
	end
endmodule

// file: timer_input_capture_channels_tb.sv
// self-checking bench for the eight channel input capture unit
// assumes tic_pkg, the unit and the trigger source model are compiled
`timescale 1ns/10ps
module timer_input_capture_channels_tb;
	typedef struct packed {
		logic [2:0] ch; // channel under test
		logic [1:0] es; // edge select code
		logic       er; // capture on rise expected
		logic       ef; // capture on fall expected
	} tic_row_t;
	logic        core_clk = 1'b0; // bench clock
	logic        rst_n;           // sync reset
	logic [11:0] paddr;           // apb address
	logic        psel;            // apb select
	logic        penable;         // apb enable
	logic        pwrite;          // apb direction
	logic [31:0] pwdata;          // apb write data
	logic [31:0] prdata;          // apb read data
	logic        pready;          // apb ready
	logic        pslverr;         // apb error
	logic [7:0]  pins;            // trigger pins
	logic        irq;             // interrupt line
	logic        go;              // toggle request to source
	logic [2:0]  tch;             // pin to toggle
	logic [31:0] rdv;             // last read data
	logic        errv;            // last error flag
	logic [31:0] c0;              // count before trigger
	logic [31:0] c1;              // captured value
	logic [31:0] mx;              // highest count seen
	tic_row_t    r;               // current row
	int          n_mismatch = 0;  // failed comparisons
	int          check_count = 0; // all comparisons
	int          cyc = 0;         // cycles run
	// one edge code per channel, every code used at least once
	tic_row_t rows [8] = '{
		{3'h0, tic_pkg::EDGE_RISE, 2'b10}, {3'h1, tic_pkg::EDGE_FALL, 2'b01},
		{3'h2, tic_pkg::EDGE_BOTH, 2'b11}, {3'h3, 2'h0, 2'b00},
		{3'h4, tic_pkg::EDGE_RISE, 2'b10}, {3'h5, tic_pkg::EDGE_FALL, 2'b01},
		{3'h6, tic_pkg::EDGE_BOTH, 2'b11}, {3'h7, tic_pkg::EDGE_RISE, 2'b10}};

	always #25 core_clk = ~core_clk;

	tic_capture_unit i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigger_input_pin(pins), .irq(irq));

	tic_trig_src i_src (.core_clk(core_clk), .rst_n(rst_n), .go(go),
		.ch(tch), .pins(pins));

	// closing report, reached from the main sequence or the timeout
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// hang guard
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// word compare
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask

	// flag compare
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rdv = prdata;
		errv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [11:0] a);
		apb(a, 1'b0, 32'h0);
	endtask

	// control word and capture value addresses of a channel
	function automatic logic [11:0] ca(input logic [2:0] c);
		return tic_pkg::A_CCTL + {7'h00, c, 2'b00};
	endfunction

	function automatic logic [11:0] va(input logic [2:0] c);
		return tic_pkg::A_CAPV + {7'h00, c, 2'b00};
	endfunction

	// one pin edge, then s cycles of quiet; pulse width is s+2 cycles
	task automatic trig(input logic [2:0] c, input int s);
		@(posedge core_clk);
		go  <= 1'b1;
		tch <= c;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (s) @(posedge core_clk);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// a short pulse is swallowed, a long one is captured on its rise
	task automatic filt_case(input logic [2:0] c, input logic [31:0] cfg,
		input int s);
		wr(ca(c), cfg);
		trig(c, s);
		trig(c, 20);
		rd(tic_pkg::A_FLAGS);
		chk_word(rdv, 32'h0);
		trig(c, 20);
		rd(tic_pkg::A_FLAGS);
		chk_word(rdv, {24'h0, 8'h01 << c});
		trig(c, 20);
	endtask

	// main sequence
	initial
	begin
		rst_n   = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		paddr   = 12'h000;
		pwrite  = 1'b0;
		pwdata  = 32'h0;
		go      = 1'b0;
		tch     = 3'h0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		// reset values and an unmapped place
		rd(tic_pkg::A_BCTL);
		chk_word(rdv, 32'h0);
		rd(tic_pkg::A_MASK);
		chk_word(rdv, 32'h0);
		apb(12'h0f0, 1'b0, 32'h0);
		chk_bit(errv, 1'b1);
		chk_word(rdv, 32'h0);
		done("reset");
		// base timer first, then the channels
		wr(tic_pkg::A_BCTL, 32'h1);
		wr(tic_pkg::A_FSEL, 32'hff);
		wr(tic_pkg::A_CHEN, 32'hff);
		foreach (rows[i])
		begin
			r = rows[i];
			wr(ca(r.ch), {30'h0, r.es});
			rd(tic_pkg::A_COUNT);
			c0 = rdv;
			trig(r.ch, 20);
			chk_bit(irq, 1'b0); // masked flag keeps the line low
			rd(tic_pkg::A_FLAGS);
			chk_word(rdv, {24'h0, 8'(r.er) << r.ch});
			rd(va(r.ch));
			c1 = rdv;
			if (r.er)
				chk_bit(c1 > c0 && c1 < c0 + 32'd40, 1'b1);
			trig(r.ch, 20);
			rd(tic_pkg::A_FLAGS);
			chk_word(rdv, {24'h0, 8'(r.ef) << r.ch});
			rd(va(r.ch));
			if (r.er && !r.ef)
				chk_word(rdv, c1);
		end
		done("edges");
		// interrupt raised, cleared by the flag read
		wr(tic_pkg::A_MASK, 32'h1);
		wr(ca(0), 32'h1);
		trig(0, 20);
		chk_bit(irq, 1'b1);
		rd(tic_pkg::A_FLAGS);
		chk_word(rdv, 32'h1);
		repeat (2) @(posedge core_clk);
		chk_bit(irq, 1'b0);
		trig(0, 20);
		done("interrupt");
		// disabled channel, then waveform function selected
		wr(tic_pkg::A_CHEN, 32'hfe);
		trig(0, 20);
		rd(tic_pkg::A_FLAGS);
		chk_word(rdv, 32'h0);
		trig(0, 20);
		wr(tic_pkg::A_CHEN, 32'hff);
		wr(tic_pkg::A_FSEL, 32'hfe);
		trig(0, 20);
		rd(tic_pkg::A_FLAGS);
		chk_word(rdv, 32'h0);
		trig(0, 20);
		wr(tic_pkg::A_FSEL, 32'hff);
		done("disable");
		// filter clocks and the channel 7 debounce
		filt_case(3'h1, 32'h5, 0);
		filt_case(3'h2, 32'h9, 0);
		filt_case(3'h3, 32'hd, 0);
		filt_case(3'h7, 32'h101, 3);
		done("filter");
		// prescaler: capture on the third rise only
		wr(tic_pkg::A_PSC6, 32'h2);
		wr(ca(6), 32'h81);
		for (int k = 1; k <= 3; k++)
		begin
			trig(6, 20);
			trig(6, 20);
			rd(tic_pkg::A_FLAGS);
			chk_word(rdv, (k == 3) ? 32'h40 : 32'h0);
		end
		done("prescale");
		// mid-run reset: setup cleared, stopped timer back at zero
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(tic_pkg::A_CHEN);
		chk_word(rdv, 32'h0);
		rd(tic_pkg::A_COUNT);
		chk_word(rdv, 32'h0);
		done("midreset");
		// channel 0 match reset: count runs 0 to compare plus 1
		wr(tic_pkg::A_CMP0, 32'h5);
		wr(tic_pkg::A_BCTL, 32'h3);
		wr(tic_pkg::A_FSEL, 32'hff);
		wr(tic_pkg::A_CHEN, 32'hff);
		mx = 32'h0;
		repeat (14)
		begin
			rd(tic_pkg::A_COUNT);
			chk_bit(rdv <= 32'h6, 1'b1);
			if (rdv > mx)
				mx = rdv;
		end
		chk_word(mx, 32'h6);
		done("period");
		// gate closes after one capture, reopens on compare 5 match
		wr(tic_pkg::A_GCMP5, 32'h3);
		wr(ca(7), 32'h11);
		for (int k = 0; k < 2; k++)
		begin
			trig(7, 20);
			trig(7, 20);
			rd(tic_pkg::A_FLAGS);
			chk_word(rdv, (k == 0) ? 32'h80 : 32'h0);
		end
		wr(ca(7), 32'h31);
		repeat (10) @(posedge core_clk);
		trig(7, 20);
		trig(7, 20);
		rd(tic_pkg::A_FLAGS);
		chk_word(rdv, 32'h80);
		done("gate");
		tally_and_finish();
	end
endmodule
